// ===== fwsr_defines.svh
// What this block does
// - Host polls a program at the address being programmed.
// - Host polls an erase at an address inside a selected sector.
// - Polling bit settles alone; host takes data only from the next read.
// - Host toggle check: two full reads; unchanged bit means done, next read valid.
// - Still toggling with timeout bit high: check again; still toggling means reset.
// - Host returning to a toggle check restarts from its first double read.
// - After timeout failure the host writes the reset command.
// - Host re-reads the polling bit after seeing the timeout bit set.
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH

`define FWSR_CLK_NS      8
`define FWSR_T_RD_NS     70
`define FWSR_T_WP_NS     35
`define FWSR_SYNC_STAGES 2
`define FWSR_RD_CYC      ((`FWSR_T_RD_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WP_CYC      ((`FWSR_T_WP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)

`define FWSR_OFS_CTRL    12'h000
`define FWSR_OFS_ADDR    12'h004
`define FWSR_OFS_DATA    12'h008
`define FWSR_OFS_STATUS  12'h00c
`define FWSR_OFS_RDATA   12'h010

`define FWSR_CTRL_OP_LSB 0
`define FWSR_CTRL_START  3
`define FWSR_CTRL_ABORT  4

`define FWSR_ST_BUSY     0
`define FWSR_ST_DONE     1
`define FWSR_ST_FAIL     2
`define FWSR_ST_TIMEOUT  3
`define FWSR_ST_READY    4
`define FWSR_ST_WINDOW   5
`define FWSR_ST_TOGGLE2  6
`define FWSR_ST_ABORTED  7

`define FWSR_POLL_BIT    7
`define FWSR_TOG1_BIT    6
`define FWSR_TOUT_BIT    5
`define FWSR_WIN_BIT     3
`define FWSR_TOG2_BIT    2

`define FWSR_RESET_CMD   8'hf0

`endif

// ===== fwsr_pkg.sv
// Purpose: types shared by the flash status controller
// Assumes: constants live in fwsr_defines.svh
// Notes:   none
package fwsr_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_POLL,
    OP_TOGGLE,
    OP_RESET
  } fwsr_op_type;

  typedef enum {
    S_IDLE,
    S_READ,
    S_WRITE,
    S_P1,
    S_PRE,
    S_PV,
    S_T1,
    S_T2,
    S_T3,
    S_T4,
    S_TV,
    S_RESET
  } fwsr_state_type;

  typedef enum {
    B_IDLE,
    B_SETUP,
    B_ACT,
    B_REC
  } fwsr_bus_type;

endpackage

// ===== fwsr_bus_cycle.sv
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: flash data pins pass two flip-flops before use
// Notes:   read strobe held long enough to cover synchroniser delay
`timescale 1ns/1ps
`default_nettype none
`include "fwsr_defines.svh"

module fwsr_bus_cycle
  import fwsr_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DQ_W   = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              req,
  input  wire logic              req_wr,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DQ_W-1:0]   req_wdata,
  output logic                   done,
  output logic [DQ_W-1:0]        rd_data,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]        flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);

  localparam logic [7:0] RD_LEN = 8'(`FWSR_RD_CYC + `FWSR_SYNC_STAGES - 1);
  localparam logic [7:0] WP_LEN = 8'(`FWSR_WP_CYC - 1);

  fwsr_bus_type    phase_reg;
  logic [7:0]      cnt_reg;
  logic            wr_reg;
  logic [DQ_W-1:0] dq_s1_reg;
  logic [DQ_W-1:0] dq_s2_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else if (ce) begin
      dq_s1_reg <= flash_dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg     <= B_IDLE;
      cnt_reg       <= '0;
      wr_reg        <= 1'b0;
      done          <= 1'b0;
      rd_data       <= '0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
    end else if (ce) begin
      done <= 1'b0;
      unique case (phase_reg)
        B_IDLE: begin
          if (req) begin
            wr_reg        <= req_wr;
            flash_addr    <= req_addr;
            flash_dq_out  <= req_wdata;
            flash_dq_oe_n <= ~req_wr;
            flash_ce_n    <= 1'b0;
            phase_reg     <= B_SETUP;
          end
        end
        B_SETUP: begin
          cnt_reg    <= wr_reg ? WP_LEN : RD_LEN;
          flash_oe_n <= wr_reg;
          flash_we_n <= ~wr_reg;
          phase_reg  <= B_ACT;
        end
        B_ACT: begin
          if (cnt_reg == 8'h00) begin
            if (!wr_reg) begin
              rd_data <= dq_s2_reg;
            end
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            phase_reg  <= B_REC;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        B_REC: begin
          flash_ce_n    <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          done          <= 1'b1;
          phase_reg     <= B_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== fwsr_ctrl.sv
// Purpose: host controller running polling and toggle checks on a flash
// Assumes: APB slave with fixed no-wait answer; flash pins are async
// Notes:   start while busy is ignored; abort stops after the current cycle
`timescale 1ns/1ps
`default_nettype none
`include "fwsr_defines.svh"

module fwsr_ctrl
  import fwsr_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DQ_W   = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]        flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  input  wire logic              ready_busy_out_n
);

  fwsr_state_type    state_reg;
  fwsr_op_type       op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DQ_W-1:0]   data_reg;
  logic [DQ_W-1:0]   rdata_reg;
  logic              done_reg;
  logic              fail_reg;
  logic              timeout_reg;
  logic              window_reg;
  logic              toggle2_reg;
  logic              aborted_reg;
  logic              abort_reg;
  logic              pend_reg;
  logic              tog_prev_reg;
  logic              rdy_s1_reg;
  logic              rdy_s2_reg;

  logic              bus_req;
  logic              bus_wr;
  logic [ADDR_W-1:0] bus_addr;
  logic [DQ_W-1:0]   bus_wdata;
  logic              bus_done;
  logic [DQ_W-1:0]   bus_rdata;
  logic              wr_acc;
  logic              setup;
  logic              start;
  logic              busy;
  logic              mapped;
  logic [31:0]       rd_mux;
  logic              poll_ok;
  logic              tog_same;

  function automatic logic is_mapped(input logic [11:0] a);
    return a == `FWSR_OFS_CTRL || a == `FWSR_OFS_ADDR || a == `FWSR_OFS_DATA ||
           a == `FWSR_OFS_STATUS || a == `FWSR_OFS_RDATA;
  endfunction

  // Op field of a control word; start takes it from the same write
  function automatic fwsr_op_type op_field(input logic [31:0] w);
    return fwsr_op_type'(w[`FWSR_CTRL_OP_LSB +: 3]);
  endfunction

  assign busy    = state_reg != S_IDLE;
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && is_mapped(paddr);
  assign start   = wr_acc && paddr == `FWSR_OFS_CTRL && pwdata[`FWSR_CTRL_START] && !busy;
  assign mapped  = is_mapped(paddr);
  assign pready  = 1'b1;

  // Compare against expected top bit of programmed datum
  assign poll_ok  = bus_rdata[`FWSR_POLL_BIT] == data_reg[`FWSR_POLL_BIT];
  assign tog_same = bus_rdata[`FWSR_TOG1_BIT] == tog_prev_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `FWSR_OFS_CTRL:   rd_mux = 32'(op_reg);
      `FWSR_OFS_ADDR:   rd_mux = 32'(addr_reg);
      `FWSR_OFS_DATA:   rd_mux = 32'(data_reg);
      `FWSR_OFS_RDATA:  rd_mux = 32'(rdata_reg);
      `FWSR_OFS_STATUS: begin
        rd_mux[`FWSR_ST_BUSY]    = busy;
        rd_mux[`FWSR_ST_DONE]    = done_reg;
        rd_mux[`FWSR_ST_FAIL]    = fail_reg;
        rd_mux[`FWSR_ST_TIMEOUT] = timeout_reg;
        rd_mux[`FWSR_ST_READY]   = rdy_s2_reg;
        rd_mux[`FWSR_ST_WINDOW]  = window_reg;
        rd_mux[`FWSR_ST_TOGGLE2] = toggle2_reg;
        rd_mux[`FWSR_ST_ABORTED] = aborted_reg;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data and error prepared in setup, presented in access phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_reg   <= OP_READ;
      addr_reg <= '0;
      data_reg <= '0;
    end else if (ce && wr_acc && !busy) begin
      if (paddr == `FWSR_OFS_CTRL) begin
        op_reg <= op_field(pwdata);
      end
      if (paddr == `FWSR_OFS_ADDR) begin
        addr_reg <= pwdata[ADDR_W-1:0];
      end
      if (paddr == `FWSR_OFS_DATA) begin
        data_reg <= pwdata[DQ_W-1:0];
      end
    end
  end

  // Ready/busy pin is asynchronous to mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
    end else if (ce) begin
      rdy_s1_reg <= ready_busy_out_n;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      abort_reg <= 1'b0;
    end else if (ce) begin
      if (wr_acc && paddr == `FWSR_OFS_CTRL && pwdata[`FWSR_CTRL_ABORT] && busy) begin
        abort_reg <= 1'b1;
      end else if (!busy) begin
        abort_reg <= 1'b0;
      end
    end
  end

  // Status flags seen on every read cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timeout_reg <= 1'b0;
      window_reg  <= 1'b0;
      toggle2_reg <= 1'b0;
    end else if (ce && bus_done && !bus_wr) begin
      timeout_reg <= bus_rdata[`FWSR_TOUT_BIT];
      window_reg  <= bus_rdata[`FWSR_WIN_BIT];
      toggle2_reg <= bus_rdata[`FWSR_TOG2_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (ce) begin
      if (bus_req) begin
        pend_reg <= 1'b1;
      end else if (bus_done) begin
        pend_reg <= 1'b0;
      end
    end
  end

  assign bus_req   = busy && !pend_reg;
  assign bus_wr    = state_reg == S_WRITE || state_reg == S_RESET;
  assign bus_addr  = addr_reg;
  assign bus_wdata = state_reg == S_RESET ? DQ_W'(`FWSR_RESET_CMD) : data_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      rdata_reg    <= '0;
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      aborted_reg  <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else if (ce) begin
      if (start) begin
        done_reg    <= 1'b0;
        fail_reg    <= 1'b0;
        aborted_reg <= 1'b0;
        unique case (op_field(pwdata))
          OP_READ:   state_reg <= S_READ;
          OP_WRITE:  state_reg <= S_WRITE;
          OP_POLL:   state_reg <= S_P1;
          OP_TOGGLE: state_reg <= S_T1;
          OP_RESET:  state_reg <= S_RESET;
          default:   state_reg <= S_IDLE;
        endcase
      end else if (bus_done && abort_reg && state_reg != S_RESET) begin
        aborted_reg <= 1'b1;
        done_reg    <= 1'b1;
        state_reg   <= S_IDLE;
      end else if (bus_done) begin
        unique case (state_reg)
          S_READ, S_PV, S_TV: begin
            rdata_reg <= bus_rdata;
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end
          S_WRITE, S_RESET: begin
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end
          S_P1: begin
            if (poll_ok) begin
              state_reg <= S_PV;
            end else if (bus_rdata[`FWSR_TOUT_BIT]) begin
              state_reg <= S_PRE;
            end
          end
          S_PRE: begin
            if (poll_ok) begin
              state_reg <= S_PV;
            end else begin
              fail_reg  <= 1'b1;
              state_reg <= S_RESET;
            end
          end
          S_T1: begin
            tog_prev_reg <= bus_rdata[`FWSR_TOG1_BIT];
            state_reg    <= S_T2;
          end
          S_T2: begin
            if (tog_same) begin
              state_reg <= S_TV;
            end else if (bus_rdata[`FWSR_TOUT_BIT]) begin
              state_reg <= S_T3;
            end else begin
              state_reg <= S_T1;
            end
          end
          S_T3: begin
            tog_prev_reg <= bus_rdata[`FWSR_TOG1_BIT];
            state_reg    <= S_T4;
          end
          S_T4: begin
            if (tog_same) begin
              state_reg <= S_TV;
            end else begin
              fail_reg  <= 1'b1;
              state_reg <= S_RESET;
            end
          end
          S_IDLE: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  fwsr_bus_cycle #(
    .ADDR_W (ADDR_W),
    .DQ_W   (DQ_W)
  ) u_bus (
    .mclk          (mclk),
    .rst           (rst),
    .ce            (ce),
    .req           (bus_req),
    .req_wr        (bus_wr),
    .req_addr      (bus_addr),
    .req_wdata     (bus_wdata),
    .done          (bus_done),
    .rd_data       (bus_rdata),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n)
  );

endmodule
`default_nettype wire

// ===== fwsr_flash_model.sv
// Purpose: flash device model answering status reads
// Assumes: bench arms each embedded operation by a pulse on go
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
  input  wire logic [21:0] addr,
  input  wire logic [7:0]  dq_o,
  output logic [7:0]       dq_i,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic             rb_n,
  input  wire logic        go,
  input  wire logic [3:0]  reads,
  input  wire logic        erase,
  input  wire logic        stuck,
  input  wire logic        susp,
  input  wire logic [7:0]  data,
  output logic [7:0]       wr_data,
  output logic [21:0]      ra
);
  int         left = 0;
  logic       fail_reg = 1'b0;
  logic       t1_reg = 1'b0;
  logic       t2_reg = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic       busy;
  assign busy = left != 0 || fail_reg;
  // Status while busy, array data once done
  assign val = !busy ? (erase ? 8'hff : data) :
               {erase ? susp : ~data[7], t1_reg, fail_reg, 1'b0, erase, t2_reg, 2'b00};
  assign dq_i = (!ce_n && !oe_n) ? val : ~last;
  assign rb_n = busy && !susp ? 1'b0 : 1'b1;
  // Read count stands in for every timed status window, protected ones too
  always @(posedge go) begin
    left = reads;
    fail_reg = stuck;
  end
  always @(posedge oe_n) begin
    if (!ce_n) begin
      last = val;
      ra = addr;
      if (busy) begin
        // Suspended erase holds toggle bit 6 and the count; bit 2 still toggles
        if (!susp) begin
          t1_reg = ~t1_reg;
          left = left > 0 ? left - 1 : 0;
        end
        t2_reg = t2_reg ^ erase;
      end
    end
  end
  always @(posedge we_n) begin
    wr_data = dq_o;
    if (dq_o == 8'hf0) begin
      fail_reg = 1'b0;
      left = 0;
    end
  end
endmodule
`default_nettype wire

// ===== fwsr_ctrl_monitor.sv
// Purpose: concurrent checks on the bus and flash pins
// Assumes: checks paused while clock enable is low
// Notes:   bound onto every fwsr_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module fwsr_ctrl_monitor #(
  parameter int ADDR_W = 22
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_dq_oe_n,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  logic bad;
  assign bad = paddr > 12'h010 || paddr[1:0] != 2'b00;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !ce);
  pready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low");
  unmapped_err_a: assert property (psel && !penable |=> pslverr == $past(bad))
    else $error("pslverr wrong");
  addr_hold_a: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("flash address moved");
  read_release_a: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n)
    else $error("bad read strobes");
  write_drive_a: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n)
    else $error("bad write strobes");
  read_width_a: assert property ($fell(flash_oe_n) |->
    (!flash_oe_n)[*8] ##1 (!flash_oe_n)[*3] ##1 flash_oe_n)
    else $error("read strobe width");
  write_width_a: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*5] ##1 flash_we_n)
    else $error("write strobe width");
  read_close_a: assert property ($rose(flash_oe_n) |=> $rose(flash_ce_n))
    else $error("select not closed");
  idle_gap_a: assert property ($rose(flash_ce_n) |-> flash_ce_n[*2])
    else $error("cycles too close");
  cover property ($fell(flash_oe_n));
  cover property ($fell(flash_we_n));
  cover property (psel && penable && bad);
endmodule
bind fwsr_ctrl fwsr_ctrl_monitor #(.ADDR_W(ADDR_W)) fwsr_ctrl_monitor_i (
  .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_oe_n(flash_dq_oe_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the flash status controller
// Assumes: model stays busy for the reads it is armed with
// Notes:   fixed seed, so every run repeats
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fwsr_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1, susp = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, st, fz;
  logic        pready, pslverr, er, dq_oe_n, ce_n, oe_n, we_n, rb_n;
  logic [21:0] fad, ra, fa_v;
  logic [7:0]  dq_out, dq_in, dq_dev, wr_data;
  logic [3:0]  reads = 4'h0;
  logic        erase = 1'b0, stuck = 1'b0;
  logic [7:0]  data = 8'h00;
  int          errors = 0;
  int          samples_checked = 0;
  int          seed = 32'hbe27c185;
  fwsr_op_type ops [4] = '{OP_READ, OP_POLL, OP_POLL, OP_TOGGLE};
  assign dq_in = dq_oe_n ? dq_dev : dq_out;
  always #4 mclk = ~mclk;
  fwsr_ctrl fwsr_ctrl_i (
    .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(fad), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_out_n(rb_n)
  );
  fwsr_flash_model fwsr_flash_model_i (
    .addr(fad), .dq_o(dq_out), .dq_i(dq_dev), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rb_n(rb_n), .go(go), .reads(reads), .erase(erase), .stuck(stuck), .data(data),
    .wr_data(wr_data), .ra(ra), .susp(susp)
  );
  function automatic logic [31:0] exp_word(input logic e, input logic [7:0] d);
    return {24'h0, e ? 8'hff : d};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    errors++;
    $display("ERROR %s expected answer seen timeout", nm);
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic arm(input logic [3:0] n, input logic e, input logic s);
    reads <= n;
    erase <= e;
    stuck <= s;
    data <= 8'($random(seed));
    fa_v <= 22'($random(seed));
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic start(input fwsr_op_type op, input logic [31:0] d);
    apb(1'b1, 12'h004, {10'h0, fa_v});
    apb(1'b1, 12'h008, d);
    apb(1'b1, 12'h000, 32'h8 | 32'(op));
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 2000);
    if (n >= 2000) hang("done");
    st = rd;
    apb(1'b0, 12'h010, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Ready pin needs its two sync stages before status shows it
    repeat (3) @(posedge mclk);
    apb(1'b0, 12'h00c, 32'h0);
    chk("idle status", 32'h10, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    for (int i = 0; i < 16; i++) begin
      arm(i % 4 == 0 ? 4'h0 : 4'h1 + 4'($random(seed) & 7), i % 4 == 2, 1'b0);
      start(ops[i % 4], i % 4 == 2 ? 32'h80 : {24'h0, data});
      wait_done();
      chk("status", 32'h2, st & 32'h7);
      chk("rdata", exp_word(erase, data), rd);
      chk("addr", {10'h0, fa_v}, {10'h0, ra});
    end
    // Erase held in suspend: polling one, steady toggle, ready high
    susp <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      arm(4'h3, 1'b1, 1'b0);
      start(i == 0 ? OP_POLL : OP_TOGGLE, 32'h80);
      wait_done();
      chk("suspend status", 32'h12, st & 32'h13);
      chk("suspend rdata", 32'h88, rd & 32'ha8);
    end
    susp <= 1'b0;
    arm(4'h0, 1'b0, 1'b0);
    start(OP_RESET, 32'h0);
    wait_done();
    chk("reset op", 32'hf0, {24'h0, wr_data});
    for (int i = 0; i < 2; i++) begin
      arm(4'h1, 1'b0, 1'b1);
      start(i == 0 ? OP_TOGGLE : OP_POLL, {24'h0, data});
      wait_done();
      chk("fail status", 32'he, st & 32'hf);
      chk("fail reset", 32'hf0, {24'h0, wr_data});
    end
    arm(4'hf, 1'b0, 1'b0);
    start(OP_TOGGLE, 32'h0);
    // Clock enable low must freeze the flash cycle in flight
    ce <= 1'b0;
    @(posedge mclk);
    fz = {7'h0, ce_n, oe_n, we_n, fad};
    repeat (4) @(posedge mclk);
    chk("freeze", fz, {7'h0, ce_n, oe_n, we_n, fad});
    ce <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    chk("busy", 32'h1, rd & 32'h11);
    apb(1'b1, 12'h000, 32'h10);
    wait_done();
    chk("abort", 32'h82, st & 32'h87);
    report_and_stop();
  end
endmodule
`default_nettype wire
